/* File: core/asl_pkg.sv */
package asl_pkg;

   // serial clock half period in system clock cycles
   localparam logic [15:0] SCLK_HALF_CYCLES = 16'h0004;
   // opcode plus address shifted out before the data phase
   localparam logic [5:0] CMD_BITS = 6'h20;
   // plain default for the read opcode; not a figure taken from any flash
   localparam logic [7:0] READ_OPCODE = 8'h03;
   localparam logic [23:0] START_ADDR = 24'h00_0000;
   // total stored image length of the whole chain, in bits
   localparam logic [31:0] IMAGE_BITS = 32'h0000_0400;
   // wait for the completion pin after the last bit
   localparam logic [15:0] DONE_TIMEOUT_CYCLES = 16'h0040;
   localparam logic [15:0] INIT_CYCLES = 16'h0010;
   localparam logic [15:0] ERR_PULSE_CYCLES = 16'h0004;
   // deselected gap after an error pulse, covers the pin synchroniser lag
   localparam logic [15:0] GAP_CYCLES = 16'h0008;

   typedef enum logic [3:0] {
      ASL_IDLE,
      ASL_SELECT,
      ASL_CMD,
      ASL_DATA,
      ASL_DONE_WAIT,
      ASL_INIT,
      ASL_USER,
      ASL_ERROR,
      ASL_GAP
   } asl_state_t;

endpackage

/* File: core/asl_pin_sync.sv */
`timescale 1ns/1ns
module asl_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_pin,
   output logic [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         // a change is taken once the second and third stages agree
         always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
               meta[g] <= RESET_VAL[g];
               s2[g] <= RESET_VAL[g];
               s3[g] <= RESET_VAL[g];
               o_level[g] <= RESET_VAL[g];
            end else begin
               meta[g] <= i_pin[g];
               s2[g] <= meta[g];
               s3[g] <= s2[g];
               if (s2[g] == s3[g]) begin
                  o_level[g] <= s3[g];
               end
            end
         end
      end
   endgenerate
endmodule

/* File: core/asl_clk_div.sv */
`timescale 1ns/1ns
module asl_clk_div #(
   parameter logic [15:0] HALF = 16'h0004
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_run,
   output logic o_sclk,
   output logic o_rise,
   output logic o_fall
);
   logic [15:0] cnt;
   logic flip;

   assign flip = i_run && (cnt == HALF - 16'h0001);
   // pulses mark the edge at which o_sclk changes
   assign o_rise = flip && !o_sclk;
   assign o_fall = flip && o_sclk;

   // dropping the run request clears the count and forces o_sclk low, so the idle level stays low
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !i_run) begin
         cnt <= 16'h0000;
         o_sclk <= 1'b0;
      end else if (flip) begin
         cnt <= 16'h0000;
         o_sclk <= ~o_sclk;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule

/* File: core/asl_loader.sv */
`timescale 1ns/1ns
module asl_loader #(
   parameter logic [15:0] SCLK_HALF = asl_pkg::SCLK_HALF_CYCLES,
   parameter logic [7:0] OPCODE = asl_pkg::READ_OPCODE,
   parameter logic [23:0] ADDR = asl_pkg::START_ADDR,
   parameter logic [31:0] IMAGE_LEN = asl_pkg::IMAGE_BITS,
   parameter logic [15:0] DONE_TIMEOUT = asl_pkg::DONE_TIMEOUT_CYCLES,
   parameter logic [15:0] INIT_LEN = asl_pkg::INIT_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   output logic o_serial_clock_line,
   output logic o_select_out_n,
   output logic o_command_out,
   input wire logic i_serial_data_in,
   input wire logic i_load_complete,
   output logic o_load_complete,
   output logic o_load_complete_oe_n,
   input wire logic i_config_error_n,
   output logic o_config_error_n,
   output logic o_config_error_oe_n,
   output logic o_cfg_data,
   output logic o_cfg_valid,
   output logic o_loading,
   output logic o_initializing,
   output logic o_user_mode
);
   import asl_pkg::*;

   asl_state_t state;
   logic [15:0] cnt;
   logic [5:0] rise_cnt;
   logic [31:0] bit_cnt;
   logic [31:0] shift;
   logic sclk_run;
   logic sclk_rise;
   logic sclk_fall;
   logic data_in;
   logic done_in;
   logic err_in_n;
   logic premature;
   logic [2:0] pins_sync;

   asl_pin_sync #(
      .WIDTH(3),
      .RESET_VAL(3'h5)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin({i_config_error_n, i_load_complete, i_serial_data_in}),
      .o_level(pins_sync)
   );

   assign data_in = pins_sync[0];
   assign done_in = pins_sync[1];
   assign err_in_n = pins_sync[2];

   // the clock runs only while the command or data phase is active
   assign sclk_run = (state == ASL_CMD) || (state == ASL_DATA);

   asl_clk_div #(
      .HALF(SCLK_HALF)
   ) u_clk (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_run(sclk_run),
      .o_sclk(o_serial_clock_line),
      .o_rise(sclk_rise),
      .o_fall(sclk_fall)
   );

   // completion pin is held low by us while loading, so a high here is a fault
   assign premature = done_in && ((state == ASL_CMD) || (state == ASL_DATA));

   // sequencing
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state <= ASL_IDLE;
         cnt <= 16'h0000;
         rise_cnt <= 6'h00;
         bit_cnt <= 32'h0000_0000;
      end else begin
         case (state)
            ASL_IDLE: begin
               // a chain member holding the error line low keeps us waiting
               if (err_in_n) begin
                  state <= ASL_SELECT;
                  cnt <= 16'h0000;
               end
            end
            ASL_SELECT: begin
               // half a clock period of select setup before the command phase starts the clock
               if (cnt == SCLK_HALF - 16'h0001) begin
                  state <= ASL_CMD;
                  rise_cnt <= 6'h00;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            ASL_CMD: begin
               if (premature) begin
                  state <= ASL_ERROR;
                  cnt <= 16'h0000;
               end else if (!err_in_n) begin
                  state <= ASL_IDLE;
               end else begin
                  if (sclk_rise) begin
                     rise_cnt <= rise_cnt + 6'h01;
                  end
                  // this falling edge launches the first data bit; nothing taken yet
                  if (sclk_fall && rise_cnt == CMD_BITS) begin
                     state <= ASL_DATA;
                     bit_cnt <= 32'h0000_0000;
                  end
               end
            end
            ASL_DATA: begin
               if (premature) begin
                  state <= ASL_ERROR;
                  cnt <= 16'h0000;
               end else if (!err_in_n) begin
                  state <= ASL_IDLE;
               end else if (sclk_fall) begin
                  bit_cnt <= bit_cnt + 32'h0000_0001;
                  // one image length for the whole chain, one flash
                  if (bit_cnt == IMAGE_LEN - 32'h0000_0001) begin
                     state <= ASL_DONE_WAIT;
                     cnt <= 16'h0000;
                  end
               end
            end
            ASL_DONE_WAIT: begin
               if (!err_in_n) begin
                  state <= ASL_IDLE;
               end else if (done_in) begin
                  state <= ASL_INIT;
                  cnt <= 16'h0000;
               end else if (cnt == DONE_TIMEOUT - 16'h0001) begin
                  state <= ASL_ERROR;
                  cnt <= 16'h0000;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            ASL_INIT: begin
               if (!err_in_n) begin
                  state <= ASL_IDLE;
               end else if (cnt == INIT_LEN - 16'h0001) begin
                  state <= ASL_USER;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            ASL_USER: begin
               // only a reset reloads once in user mode
               state <= ASL_USER;
            end
            ASL_ERROR: begin
               if (cnt == ERR_PULSE_CYCLES - 16'h0001) begin
                  state <= ASL_GAP;
                  cnt <= 16'h0000;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            ASL_GAP: begin
               // lets our own error pulse pass the synchroniser before idle looks at it
               if (cnt == GAP_CYCLES - 16'h0001) begin
                  state <= ASL_IDLE;
                  cnt <= 16'h0000;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            default: begin
               state <= ASL_IDLE;
            end
         endcase
      end
   end

   // command shifter, msb first, changes on falling edges so the flash
   // samples a settled bit on the rising edge
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         shift <= 32'h0000_0000;
         o_command_out <= 1'b0;
      end else if (state == ASL_SELECT && cnt == SCLK_HALF - 16'h0001) begin
         shift <= {OPCODE[6:0], ADDR, 1'b0};
         o_command_out <= OPCODE[7];
      end else if (state == ASL_CMD && sclk_fall && rise_cnt < CMD_BITS) begin
         o_command_out <= shift[31];
         shift <= {shift[30:0], 1'b0};
      end else if (state != ASL_CMD) begin
         o_command_out <= 1'b0;
      end
   end

   // data taken on the falling edge; the bit was launched at the previous falling edge
   // and sat stable for a full period, longer than the synchroniser lag
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_cfg_data <= 1'b0;
         o_cfg_valid <= 1'b0;
      end else begin
         o_cfg_valid <= 1'b0;
         if (state == ASL_DATA && sclk_fall && !premature && err_in_n) begin
            o_cfg_data <= data_in;
            o_cfg_valid <= 1'b1;
         end
      end
   end

   // single select line: one flash serves the chain; stays high in user mode
   // so an embedded flash controller may take the flash over
   assign o_select_out_n = !((state == ASL_SELECT) || sclk_run);

   // completion pin held low while loading, released afterwards
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_load_complete_oe_n <= 1'b0;
      end else begin
         case (state)
            ASL_DONE_WAIT, ASL_INIT, ASL_USER: o_load_complete_oe_n <= 1'b1;
            default: o_load_complete_oe_n <= 1'b0;
         endcase
      end
   end
   assign o_load_complete = 1'b0;

   // error pin driven low only for the restart pulse
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_config_error_oe_n <= 1'b1;
      end else begin
         o_config_error_oe_n <= !(state == ASL_ERROR);
      end
   end
   assign o_config_error_n = 1'b0;

   assign o_loading = sclk_run || (state == ASL_SELECT) || (state == ASL_DONE_WAIT);
   assign o_initializing = (state == ASL_INIT);
   assign o_user_mode = (state == ASL_USER);

   // checks
   localparam int SCK_WAIT = 8;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_clk_running: assert property (
      (state == ASL_CMD) |-> ##[1:SCK_WAIT] ($changed(o_serial_clock_line) || !sclk_run)
   ) else $error("serial clock stalled during command phase");

   a_select_first: assert property (
      $rose(o_serial_clock_line) |-> !o_select_out_n && !$past(o_select_out_n)
   ) else $error("clock edge without prior flash select");

   a_cmd_setup: assert property (
      (state == ASL_CMD) && $changed(o_command_out) && $past(state == ASL_CMD)
         |-> !o_serial_clock_line && $past(o_serial_clock_line)
   ) else $error("command bit changed off a falling edge");

   a_capture_fall: assert property (
      o_cfg_valid |-> $fell(o_serial_clock_line) && (o_cfg_data == $past(data_in))
   ) else $error("data not captured at falling edge");

   a_pins_driven: assert property (
      sclk_run |-> !o_load_complete_oe_n && o_config_error_oe_n
   ) else $error("completion pin not held low while loading");

   a_err_pulse: assert property (
      $fell(o_config_error_oe_n) |-> !o_config_error_oe_n[*4] ##1 o_config_error_oe_n
   ) else $error("error pulse has wrong length");

   a_premature: assert property (
      premature |=> (state == ASL_ERROR) ##1 !o_config_error_oe_n
   ) else $error("early completion did not raise error");

   a_timeout: assert property (
      (state == ASL_DONE_WAIT) && !done_in && err_in_n && (cnt == DONE_TIMEOUT - 16'h0001)
         |=> (state == ASL_ERROR)
   ) else $error("missing completion did not raise error");

   a_release_done: assert property (
      $rose(state == ASL_DONE_WAIT) |=> o_load_complete_oe_n && o_select_out_n
   ) else $error("completion pin not released after load");

   a_init_order: assert property (
      $rose(state == ASL_INIT) |-> $past(done_in) ##1 !o_user_mode
   ) else $error("initialization began before completion high");

   // the divider parks one edge after the run request drops
   a_deselect: assert property (
      (state == ASL_ERROR) || (state == ASL_GAP)
         |-> o_select_out_n && (!o_serial_clock_line || $past(sclk_run))
   ) else $error("flash still selected during restart");

   a_cmd_first: assert property (
      $rose(state == ASL_CMD) |-> (o_command_out == OPCODE[7])
   ) else $error("first command bit not the opcode msb");

   a_sel_in_load: assert property (
      (state == ASL_DATA) |-> !o_select_out_n
   ) else $error("flash deselected during data phase");

   a_no_clk_idle: assert property (
      !sclk_run && !$past(sclk_run) |-> !o_serial_clock_line
   ) else $error("serial clock not parked low outside a transfer");

   // an external error low during a transfer aborts without our own pulse
   a_abort_idle: assert property (
      ((state == ASL_CMD) || (state == ASL_DATA)) && !premature && !err_in_n
         |=> (state == ASL_IDLE) && o_select_out_n
   ) else $error("external error did not abort the transfer");

   a_image_end: assert property (
      (state == ASL_DATA) && sclk_fall && !premature && err_in_n
         && (bit_cnt == IMAGE_LEN - 32'h0000_0001)
         |=> (state == ASL_DONE_WAIT) && o_select_out_n
   ) else $error("load did not stop after the last image bit");

   a_user_sticky: assert property (
      o_user_mode |=> o_user_mode
   ) else $error("user mode dropped without a reset");

   c_full_load: cover property ($rose(o_user_mode));
   c_restart: cover property ($rose(state == ASL_ERROR) ##[1:20] (state == ASL_IDLE));
   c_first_bit: cover property ($rose(state == ASL_DATA) ##[1:SCK_WAIT] o_cfg_valid);
   c_premature: cover property (premature);
   c_abort: cover property ((state == ASL_DATA) ##1 (state == ASL_IDLE));
endmodule

/* File: verification/asl_flash_model.sv */
`timescale 1ns/1ns
module asl_flash_model (
   input wire logic i_sclk,
   input wire logic i_sel_n,
   input wire logic i_cmd,
   output logic o_data,
   output logic [31:0] o_cmd_word
);
   logic [7:0] rise_n;
   logic [31:0] out_n;
   logic drv;
   initial begin
      rise_n = 8'h00;
      out_n = 32'h0000_0000;
      drv = 1'b0;
      o_cmd_word = 32'h0000_0000;
   end
   // command sampled on the rising clock while selected
   always @(posedge i_sclk or posedge i_sel_n) begin
      if (i_sel_n) begin
         rise_n <= 8'h00;
      end else if (rise_n < 8'h20) begin
         o_cmd_word <= {o_cmd_word[30:0], i_cmd};
         rise_n <= rise_n + 8'h01;
      end
   end
   // data launched on each falling clock once the command is complete
   always @(negedge i_sclk or posedge i_sel_n) begin
      if (i_sel_n) begin
         out_n <= 32'h0000_0000;
      end else if (rise_n == 8'h20) begin
         drv <= ((out_n % 3) == 0) ^ out_n[2];
         out_n <= out_n + 32'h0000_0001;
      end
   end
   // no pull on this line: a released line shows the inverse, never a stale bit
   assign o_data = i_sel_n ? ~drv : drv;
endmodule

/* File: verification/asl_loader_tb_top.sv */
`timescale 1ns/1ns
module asl_loader_tb_top;
   import asl_pkg::*;
   localparam int IMG = 64;
   logic clk, rst_n, sclk, sel_n, cmd, din, lc_o, lc_oe_n, er_o, er_oe_n;
   logic cfg_data, cfg_valid, loading, init, user, ext_lc_low, ext_er_low, lc_w, er_w;
   logic [31:0] cmd_word;
   logic ext_lc_high;
   logic cap [0:IMG-1];
   int cap_n, bad_count, checks_done, cyc;
   // open-drain wires: pulled up unless someone drives them low
   // ext_lc_high models a fault that lifts the completion wire too early
   assign lc_w = ((lc_oe_n | lc_o) & ~ext_lc_low) | ext_lc_high;
   assign er_w = (er_oe_n | er_o) & ~ext_er_low;
   asl_loader #(.IMAGE_LEN(32'h0000_0040)) uut (
      .i_clk(clk), .i_rst_n(rst_n), .o_serial_clock_line(sclk), .o_select_out_n(sel_n),
      .o_command_out(cmd), .i_serial_data_in(din), .i_load_complete(lc_w),
      .o_load_complete(lc_o), .o_load_complete_oe_n(lc_oe_n), .i_config_error_n(er_w),
      .o_config_error_n(er_o), .o_config_error_oe_n(er_oe_n), .o_cfg_data(cfg_data),
      .o_cfg_valid(cfg_valid), .o_loading(loading), .o_initializing(init),
      .o_user_mode(user));
   asl_flash_model flash (
      .i_sclk(sclk), .i_sel_n(sel_n), .i_cmd(cmd), .o_data(din),
      .o_cmd_word(cmd_word));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task final_report;
      if (bad_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cfg_valid === 1'b1) begin
         if (cap_n < IMG) cap[cap_n] = cfg_data;
         cap_n++;
      end
      if (cyc == 20000) begin
         bad_count++;
         final_report;
      end
   end
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tick;
      @(posedge clk);
      #1;
   endtask
   task do_reset;
      rst_n = 1'b0;
      ext_lc_low = 1'b0;
      ext_er_low = 1'b0;
      ext_lc_high = 1'b0;
      repeat (2) tick;
      rst_n = 1'b1;
      cap_n = 0;
   endtask
   task wait_sel(input logic lvl);
      for (int n = 0; n < 3000 && sel_n !== lvl; n++) tick;
   endtask
   task wait_user(output int il);
      il = 0;
      for (int n = 0; n < 4000 && user !== 1'b1; n++) begin
         if (init === 1'b1) il++;
         tick;
      end
   endtask
   task t_normal;
      int il;
      do_reset;
      wait_sel(1'b0);
      check("sclk_at_select", 32'(sclk), 32'h0000_0000);
      check("loading_on", 32'(loading), 32'h0000_0001);
      check("done_held_low", 32'(lc_oe_n), 32'h0000_0000);
      wait_user(il);
      check("cmd_word", cmd_word, {READ_OPCODE, START_ADDR});
      check("bit_count", 32'(cap_n), 32'(IMG));
      for (int k = 0; k < IMG; k++) begin
         check("image_bit", 32'(cap[k]), 32'(((k % 3) == 0) ^ k[2]));
      end
      check("sel_after", 32'(sel_n), 32'h0000_0001);
      check("sclk_after", 32'(sclk), 32'h0000_0000);
      check("done_released", 32'(lc_oe_n), 32'h0000_0001);
      check("init_len", 32'(il), {16'h0000, INIT_CYCLES});
      check("user_mode", 32'(user), 32'h0000_0001);
   endtask
   task t_timeout;
      int w;
      int il;
      do_reset;
      ext_lc_low = 1'b1;
      for (int n = 0; n < 3000 && er_oe_n !== 1'b0; n++) tick;
      check("pulse_seen", 32'(er_oe_n), 32'h0000_0000);
      check("sel_in_pulse", 32'(sel_n), 32'h0000_0001);
      w = 0;
      while (er_oe_n === 1'b0 && w < 50) begin
         w++;
         tick;
      end
      check("pulse_len", 32'(w), {16'h0000, ERR_PULSE_CYCLES});
      ext_lc_low = 1'b0;
      cap_n = 0;
      wait_sel(1'b0);
      check("restart_sel", 32'(sel_n), 32'h0000_0000);
      wait_user(il);
      check("reload_user", 32'(user), 32'h0000_0001);
      check("reload_bits", 32'(cap_n), 32'(IMG));
   endtask
   task t_abort;
      int il;
      do_reset;
      for (int n = 0; n < 3000 && cap_n < 10; n++) tick;
      ext_er_low = 1'b1;
      for (int n = 0; n < 20 && sel_n !== 1'b1; n++) tick;
      check("abort_sel", 32'(sel_n), 32'h0000_0001);
      check("abort_loading", 32'(loading), 32'h0000_0000);
      check("abort_no_pulse", 32'(er_oe_n), 32'h0000_0001);
      tick;
      ext_er_low = 1'b0;
      cap_n = 0;
      wait_user(il);
      check("abort_user", 32'(user), 32'h0000_0001);
      check("abort_bits", 32'(cap_n), 32'(IMG));
   endtask
   task t_early;
      int il;
      do_reset;
      wait_sel(1'b0);
      repeat (20) tick;
      ext_lc_high = 1'b1;
      for (int n = 0; n < 30 && er_oe_n !== 1'b0; n++) tick;
      check("early_pulse", 32'(er_oe_n), 32'h0000_0000);
      check("early_sel", 32'(sel_n), 32'h0000_0001);
      ext_lc_high = 1'b0;
      cap_n = 0;
      wait_user(il);
      check("early_user", 32'(user), 32'h0000_0001);
      check("early_bits", 32'(cap_n), 32'(IMG));
   endtask
   initial begin
      rst_n = 1'b0;
      ext_lc_low = 1'b0;
      ext_er_low = 1'b0;
      ext_lc_high = 1'b0;
      bad_count = 0;
      checks_done = 0;
      cyc = 0;
      cap_n = 0;
      t_normal;
      t_timeout;
      t_abort;
      t_early;
      final_report;
   end
endmodule
